// [hdl/flash_pin_pkg.sv]
// Purpose: Shared constants and types of the serial flash pin front end
// Assumes: One core clock samples every pin of the serial link
// Notes: Array geometry sizes the address fields used by the core
package flash_pin_pkg;
  // ==========================================================
  // Array geometry
  localparam int PAGE_COUNT = 4096;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_PAGES = 16;
  localparam int BLOCK32_PAGES = 128;
  localparam int BLOCK64_PAGES = 256;
  localparam int ADDR_W = 20;
  localparam int PAGE_OFS_W = 8;
  localparam int PROG_CNT_W = 9;
  localparam int SECTOR_SHIFT = 12;
  localparam int BLOCK32_SHIFT = 15;
  localparam int BLOCK64_SHIFT = 16;
  // ==========================================================
  // Link limits and pin sampling
  localparam int SCLK_MAX_MHZ = 104;
  localparam int CORE_CLK_MHZ = 250;
  localparam int SYNC_W = 6;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_LANE0 = 2;
  localparam int BIT_CNT_W = 3;
  // ==========================================================
  // Identification
  localparam int UNIQUE_ID_W = 64;
  localparam int ID_IDX_W = 4;
  localparam logic [3:0] ID_IDX_MFR = 4'h8;
  localparam logic [3:0] ID_IDX_DEV_HI = 4'h9;
  localparam logic [3:0] ID_IDX_DEV_LO = 4'ha;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;
  typedef enum logic [1:0] {ERASE_SECTOR, ERASE_BLOCK32, ERASE_BLOCK64, ERASE_CHIP} erase_kind_t;
  typedef enum logic [1:0] {PAUSE_RUN, PAUSE_ENTER, PAUSE_HELD, PAUSE_LEAVE} pause_state_t;
endpackage : flash_pin_pkg

// [hdl/pin_sample_if.sv]
// Purpose: Carries synchronised pin levels and their edges
// Assumes: Driven by the pin sampler, read by the front end
// Notes: Edges are one core cycle pulses
`timescale 1ns/1ps
interface pin_sample_if #(parameter int W = 6);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport drv (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface : pin_sample_if

// [hdl/pin_sampler.sv]
// Purpose: Two flop synchroniser with edge detection for link pins
// Assumes: Pins are asynchronous to the core clock
// Notes: Edge detect reads only the second stage and later
`timescale 1ns/1ps
module pin_sampler #(
  parameter int W = 6
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] pin_in,
  pin_sample_if.drv smp
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_nxt;
  logic [1:0] fill_r;
  logic [1:0] fill_nxt;
  logic live;

  // ==========================================================
  // Synchroniser stages
  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    // Count core clock cycles until every stage holds a real pin sample
    fill_nxt = fill_r;
    if (fill_r != 2'h3)
    begin
      fill_nxt = fill_r + 2'h1;
    end
  end

  // Reset to idle high: select and strap pins rest high
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
      fill_r <= 2'h0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Level and edge pulses; reset values never count as an edge
  assign live = (fill_r == 2'h3);
  assign smp.level = sync_r;
  assign smp.rise = sync_r & ~prev_r & {W{live}};
  assign smp.fall = ~sync_r & prev_r & {W{live}};
endmodule : pin_sampler

// [hdl/flash_pin_front.sv]
// Purpose: Pin level front end of a serial flash, single, dual and quad lanes
// Assumes: Core clock far faster than the serial clock, all pins sampled
// Notes: Instruction decoding lives in the core beyond the byte ports
//
`timescale 1ns/1ps

// Functional notes
// - Select high deselects; all data outputs float.
// - Select low enables; bytes received and read data returned.
// - After reset nothing accepted until select falls from high.
// - Single lane captures serial_in on rising serial clock.
// - Single lane drives serial_out, changing on falling serial clock.
// - Dual and quad lanes capture on rising, drive on falling.
// - Quad lanes honoured only with quad_enable_bit set.
// - With quad_enable_bit, protect and pause pins become lanes 2 and 3.
// - Write protect low blocks status writes with status lock bit.
// - Quad enable removes write protect meaning of its pin.
// - Pause low while selected floats output, ignores clock and data.
// - Pause release resumes with the next clocked bits.
// - Quad enable removes pause meaning of its pin.
// - Array of 4096 pages of 256 bytes; program wraps in page.
// - Erase units of 16, 128, 256 pages or whole array.
// - 64-bit unique number and identification bytes readable.
// - Clock may idle low or high at select edges.
// - Pause starts or ends at once if clock low, else next fall.
module flash_pin_front #(
  parameter logic [flash_pin_pkg::UNIQUE_ID_W-1:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h3c14 // Arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic select_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_lane_in,
  output logic [3:0] io_lane_out,
  output logic [3:0] io_lane_oe_out,
  input wire logic quad_enable_bit_in,
  input wire logic status_lock_bit_0_in,
  input wire flash_pin_pkg::lane_mode_t lane_mode_in,
  input wire logic drive_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_take_out,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic selected_out,
  output logic frame_end_out,
  output logic paused_out,
  output logic quad_refused_out,
  output logic status_write_block_out,
  input wire logic prog_start_in,
  input wire logic prog_phase_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] prog_addr_in,
  output logic [flash_pin_pkg::ADDR_W-1:0] prog_addr_out,
  output logic [flash_pin_pkg::PROG_CNT_W-1:0] prog_count_out,
  input wire flash_pin_pkg::erase_kind_t erase_kind_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] erase_addr_in,
  output logic [flash_pin_pkg::ADDR_W-1:0] erase_base_out,
  input wire logic [flash_pin_pkg::ID_IDX_W-1:0] id_index_in,
  output logic [7:0] id_byte_out
);
  import flash_pin_pkg::*;

  pin_sample_if #(.W(SYNC_W)) smp ();

  // ==========================================================
  // Pin sampling
  pin_sampler #(.W(SYNC_W)) u_sampler (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .pin_in({io_lane_in, sclk_in, select_n_in}),
    .smp(smp)
  );

  logic sel_lvl;
  logic sel_fall;
  logic sel_rise;
  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] lane_lvl;
  logic quad_ok;
  lane_mode_t eff_mode;

  assign sel_lvl = smp.level[PIN_SEL];
  assign sel_fall = smp.fall[PIN_SEL];
  assign sel_rise = smp.rise[PIN_SEL];
  assign sclk_lvl = smp.level[PIN_SCLK];
  assign sclk_rise = smp.rise[PIN_SCLK];
  assign sclk_fall = smp.fall[PIN_SCLK];
  assign lane_lvl = smp.level[PIN_LANE0+3:PIN_LANE0];
  // Quad only with the enable bit, else fall back to single
  assign quad_ok = quad_enable_bit_in;
  assign eff_mode = (lane_mode_in == LANE_QUAD && !quad_ok) ? LANE_SINGLE : lane_mode_in;

  // ==========================================================
  // Selection and arming
  logic armed_r;
  logic armed_nxt;
  logic active;

  // Armed only by a real high to low select transition
  always_comb
  begin
    armed_nxt = armed_r;
    if (sel_fall)
    begin
      armed_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      armed_r <= 1'b0;
    end
    else
    begin
      armed_r <= armed_nxt;
    end
  end

  assign active = armed_r && !sel_lvl;

  // ==========================================================
  // Pause control
  pause_state_t pause_r;
  pause_state_t pause_nxt;
  logic pause_pin_low;
  logic paused;

  // Pause pin has meaning only without quad enable
  assign pause_pin_low = !lane_lvl[3] && !quad_ok;

  always_comb
  begin
    pause_nxt = pause_r;
    unique case (pause_r)
      PAUSE_RUN:
        if (active && pause_pin_low)
        begin
          pause_nxt = sclk_lvl ? PAUSE_ENTER : PAUSE_HELD;
        end
      PAUSE_ENTER:
        if (!pause_pin_low)
        begin
          pause_nxt = PAUSE_RUN;
        end
        else if (sclk_fall)
        begin
          pause_nxt = PAUSE_HELD;
        end
      PAUSE_HELD:
        if (!pause_pin_low)
        begin
          pause_nxt = sclk_lvl ? PAUSE_LEAVE : PAUSE_RUN;
        end
      PAUSE_LEAVE:
        if (pause_pin_low)
        begin
          pause_nxt = PAUSE_HELD;
        end
        else if (sclk_fall)
        begin
          pause_nxt = PAUSE_RUN;
        end
    endcase
    if (!active)
    begin
      pause_nxt = PAUSE_RUN;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pause_r <= PAUSE_RUN;
    end
    else
    begin
      pause_r <= pause_nxt;
    end
  end

  assign paused = (pause_r == PAUSE_HELD) || (pause_r == PAUSE_LEAVE);

  // ==========================================================
  // Receive and transmit shifters
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [BIT_CNT_W-1:0] rx_cnt_r;
  logic [BIT_CNT_W-1:0] rx_cnt_nxt;
  logic [7:0] rx_byte_nxt;
  logic rx_valid_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic [BIT_CNT_W-1:0] tx_cnt_r;
  logic [BIT_CNT_W-1:0] tx_cnt_nxt;
  logic [3:0] out_bits_r;
  logic [3:0] out_bits_nxt;
  logic [3:0] oe_r;
  logic [3:0] oe_nxt;
  logic rose_r;
  logic rose_nxt;
  logic take;
  logic [7:0] tx_src;
  logic [7:0] rx_full;
  logic [BIT_CNT_W-1:0] step;

  assign step = (eff_mode == LANE_QUAD) ? 3'd4 : (eff_mode == LANE_DUAL) ? 3'd2 : 3'd1;

  always_comb
  begin
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_byte_nxt = rx_byte_out;
    rx_valid_nxt = 1'b0;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    out_bits_nxt = out_bits_r;
    rose_nxt = rose_r;
    take = 1'b0;
    tx_src = (tx_cnt_r == 3'd0) ? tx_byte_in : tx_sh_r;
    unique case (eff_mode)
      LANE_QUAD: rx_full = {rx_sh_r[3:0], lane_lvl};
      LANE_DUAL: rx_full = {rx_sh_r[5:0], lane_lvl[1:0]};
      default: rx_full = {rx_sh_r[6:0], lane_lvl[0]};
    endcase
    if (active && !paused)
    begin
      // Capture on rising serial clock
      if (sclk_rise)
      begin
        rose_nxt = 1'b1;
        rx_sh_nxt = rx_full;
        rx_cnt_nxt = rx_cnt_r + step;
        if (rx_cnt_nxt == 3'd0)
        begin
          rx_byte_nxt = rx_full;
          rx_valid_nxt = 1'b1;
        end
      end
      // Drive on falling serial clock, only after a first rise
      if (sclk_fall && rose_r && drive_in)
      begin
        take = (tx_cnt_r == 3'd0);
        unique case (eff_mode)
          LANE_QUAD: out_bits_nxt = tx_src[7:4];
          LANE_DUAL: out_bits_nxt = {2'b00, tx_src[7:6]};
          default: out_bits_nxt = {2'b00, tx_src[7], 1'b0};
        endcase
        unique case (eff_mode)
          LANE_QUAD: tx_sh_nxt = {tx_src[3:0], 4'h0};
          LANE_DUAL: tx_sh_nxt = {tx_src[5:0], 2'b00};
          default: tx_sh_nxt = {tx_src[6:0], 1'b0};
        endcase
        tx_cnt_nxt = tx_cnt_r + step;
      end
    end
    // Drop partial bytes when the frame ends
    if (sel_lvl)
    begin
      rx_cnt_nxt = '0;
      tx_cnt_nxt = '0;
      rose_nxt = 1'b0;
    end
    // Output enables: lane 1 single, lanes 1:0 dual, all quad
    oe_nxt = 4'h0;
    if (active && !paused && drive_in && rose_nxt)
    begin
      unique case (eff_mode)
        LANE_QUAD: oe_nxt = 4'hf;
        LANE_DUAL: oe_nxt = 4'h3;
        default: oe_nxt = 4'h2;
      endcase
    end
    if (sel_lvl)
    begin
      oe_nxt = 4'h0;
    end
    if (paused)
    begin
      oe_nxt = 4'h0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_sh_r <= 8'h00;
      rx_cnt_r <= '0;
      rx_byte_out <= 8'h00;
      rx_valid_out <= 1'b0;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= '0;
      out_bits_r <= 4'h0;
      oe_r <= 4'h0;
      rose_r <= 1'b0;
    end
    else
    begin
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_byte_out <= rx_byte_nxt;
      rx_valid_out <= rx_valid_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      out_bits_r <= out_bits_nxt;
      oe_r <= oe_nxt;
      rose_r <= rose_nxt;
    end
  end

  assign io_lane_out = out_bits_r;
  assign io_lane_oe_out = oe_r;
  assign tx_take_out = take;
  assign selected_out = active;
  assign frame_end_out = sel_rise && armed_r;
  assign paused_out = paused;
  assign quad_refused_out = (lane_mode_in == LANE_QUAD) && !quad_ok;
  // Protect pin counts only while it is not a data lane
  assign status_write_block_out = !quad_ok && !lane_lvl[2] && status_lock_bit_0_in;

  // ==========================================================
  // Program address within a page, erase alignment, identity bytes
  logic [ADDR_W-1:0] prog_addr_nxt;
  logic [PROG_CNT_W-1:0] prog_count_nxt;
  logic [ADDR_W-1:0] erase_base_nxt;
  logic [7:0] id_byte_nxt;
  logic [3:0] uid_sel;

  assign uid_sel = 4'd7 - id_index_in;

  always_comb
  begin
    prog_addr_nxt = prog_addr_out;
    prog_count_nxt = prog_count_out;
    if (prog_start_in)
    begin
      prog_addr_nxt = prog_addr_in;
      prog_count_nxt = '0;
    end
    else if (prog_phase_in && rx_valid_out)
    begin
      // Offset wraps inside the page, at most one page per program
      prog_addr_nxt[PAGE_OFS_W-1:0] = prog_addr_out[PAGE_OFS_W-1:0] + 8'h01;
      if (prog_count_out != PROG_CNT_W'(PAGE_BYTES))
      begin
        prog_count_nxt = prog_count_out + 9'h001;
      end
    end
    unique case (erase_kind_in)
      ERASE_SECTOR: erase_base_nxt = erase_addr_in & ~ADDR_W'((1 << SECTOR_SHIFT) - 1);
      ERASE_BLOCK32: erase_base_nxt = erase_addr_in & ~ADDR_W'((1 << BLOCK32_SHIFT) - 1);
      ERASE_BLOCK64: erase_base_nxt = erase_addr_in & ~ADDR_W'((1 << BLOCK64_SHIFT) - 1);
      default: erase_base_nxt = '0;
    endcase
    if (id_index_in < ID_IDX_MFR)
    begin
      id_byte_nxt = UNIQUE_ID[uid_sel[2:0]*8 +: 8];
    end
    else if (id_index_in == ID_IDX_MFR)
    begin
      id_byte_nxt = MFR_ID;
    end
    else if (id_index_in == ID_IDX_DEV_HI)
    begin
      id_byte_nxt = DEVICE_ID[15:8];
    end
    else if (id_index_in == ID_IDX_DEV_LO)
    begin
      id_byte_nxt = DEVICE_ID[7:0];
    end
    else
    begin
      id_byte_nxt = 8'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prog_addr_out <= '0;
      prog_count_out <= '0;
      erase_base_out <= '0;
      id_byte_out <= 8'h00;
    end
    else
    begin
      prog_addr_out <= prog_addr_nxt;
      prog_count_out <= prog_count_nxt;
      erase_base_out <= erase_base_nxt;
      id_byte_out <= id_byte_nxt;
    end
  end
endmodule : flash_pin_front

// [tb/flash_pin_front_properties.sv]
// Purpose: Port checks of the flash pin front end
// Assumes: About three core cycles of pin sync depth
// Notes: Bound to every front end instance
`timescale 1ns/1ps
module flash_pin_front_properties (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic select_n_in,
  input wire logic [3:0] io_lane_in,
  input wire logic [3:0] io_lane_oe_out,
  input wire logic quad_enable_bit_in,
  input wire logic status_lock_bit_0_in,
  input wire logic rx_valid_out,
  input wire logic selected_out,
  input wire logic paused_out,
  input wire logic status_write_block_out,
  input wire logic prog_start_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] prog_addr_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] prog_addr_out,
  input wire logic [flash_pin_pkg::PROG_CNT_W-1:0] prog_count_out,
  input wire flash_pin_pkg::erase_kind_t erase_kind_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] erase_addr_in,
  input wire logic [flash_pin_pkg::ADDR_W-1:0] erase_base_out
);
  import flash_pin_pkg::*;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // Lane drive and selection
  AST_DESEL_FLOAT: assert property (select_n_in [*6] |-> io_lane_oe_out == 4'h0)
    else $error("lanes driven while deselected");
  AST_DESEL_QUIET: assert property (select_n_in [*6] |-> !selected_out && !rx_valid_out)
    else $error("activity while deselected");
  AST_OE_SHAPE: assert property (io_lane_oe_out != 4'h0 |-> io_lane_oe_out inside {4'h2, 4'h3, 4'hf})
    else $error("bad lane enable pattern");
  AST_QUAD_QE: assert property (io_lane_oe_out == 4'hf |-> quad_enable_bit_in)
    else $error("quad drive without quad enable");
  // ==========================================================
  // Pause and protect pins
  AST_PAUSE_FLOAT: assert property (paused_out [*2] |-> io_lane_oe_out == 4'h0)
    else $error("lanes driven while paused");
  AST_PAUSE_QE: assert property (quad_enable_bit_in |-> !paused_out)
    else $error("pause with quad enable");
  AST_WP_BLOCK: assert property ((!quad_enable_bit_in && status_lock_bit_0_in && !io_lane_in[2]) [*4]
    |-> status_write_block_out)
    else $error("status write not blocked");
  AST_WP_QE: assert property (quad_enable_bit_in |-> !status_write_block_out)
    else $error("protect pin active with quad enable");
  // ==========================================================
  // Program and erase helpers
  AST_PROG_LOAD: assert property (prog_start_in |=>
    prog_count_out == '0 && prog_addr_out == $past(prog_addr_in))
    else $error("program start not loaded");
  AST_ERASE_SECTOR: assert property (erase_kind_in == ERASE_SECTOR |=>
    erase_base_out == ($past(erase_addr_in) & 20'hff000))
    else $error("sector base wrong");
  AST_ERASE_CHIP: assert property (erase_kind_in == ERASE_CHIP |=> erase_base_out == 20'h0)
    else $error("chip base not zero");
  // Main scenarios
  cover property (rx_valid_out);
  cover property (paused_out);
  cover property (io_lane_oe_out == 4'hf);
endmodule : flash_pin_front_properties

bind flash_pin_front flash_pin_front_properties chk_u (
  .core_clk_in, .rst_b_in, .select_n_in, .io_lane_in, .io_lane_oe_out,
  .quad_enable_bit_in, .status_lock_bit_0_in, .rx_valid_out, .selected_out, .paused_out,
  .status_write_block_out, .prog_start_in, .prog_addr_in, .prog_addr_out, .prog_count_out,
  .erase_kind_in, .erase_addr_in, .erase_base_out
);

// [tb/flash_host_model.sv]
// Purpose: Host controller model driving the flash link pins
// Assumes: Bench resolves lanes against device enables
// Notes: 24 ns half period gives the 48 ns link clock
`timescale 1ns/1ps
module flash_host_model (
  input wire logic [3:0] lane_in,
  output logic select_n_out,
  output logic sclk_out,
  output logic [3:0] lane_out
);
  logic idle_r;
  // ==========================================================
  // Idle levels, protect and pause high
  initial
  begin
    select_n_out = 1'b1;
    sclk_out = 1'b0;
    lane_out = 4'hf;
    idle_r = 1'b0;
  end
  // Select falls before any unit is clocked
  task automatic open_frame(input logic idle);
    idle_r = idle;
    sclk_out = idle;
    #1.7 select_n_out = 1'b0;
    #24 sclk_out = 1'b0;
  endtask : open_frame
  // Clock back to idle, then deselect
  task automatic close_frame();
    #24 sclk_out = idle_r;
    #24 select_n_out = 1'b1;
    lane_out = 4'hf;
    #96;
  endtask : close_frame
  // Data set in low phase, sampled at rise, msb first
  task automatic xfer(input logic [7:0] tx, input int w, input int n, output logic [7:0] rx);
    rx = 8'h00;
    repeat (n)
    begin
      case (w)
        1: lane_out[0] = tx[7];
        2: lane_out[1:0] = tx[7:6];
        default: lane_out = tx[7:4];
      endcase
      tx = tx << w;
      #24 sclk_out = 1'b1;
      case (w)
        1: rx = {rx[6:0], lane_in[1]};
        2: rx = {rx[5:0], lane_in[1:0]};
        default: rx = {rx[3:0], lane_in};
      endcase
      #24 sclk_out = 1'b0;
    end
  endtask : xfer
  task automatic set_pin(input int i, input logic v);
    lane_out[i] = v;
  endtask : set_pin
endmodule : flash_host_model

// [tb/flash_pin_front_tb_top.sv]
// Purpose: Self checking bench of the flash pin front end
// Assumes: Host model drives the link, bench plays the core
// Notes: Received bytes checked against a queue of notes
`timescale 1ns/1ps
module flash_pin_front_tb_top;
  import flash_pin_pkg::*;
  localparam logic [63:0] UID = 64'h1122_3344_5566_7788; // Arbitrary value
  localparam logic [7:0] MFR = 8'h6e; // Arbitrary value
  localparam logic [15:0] DEV = 16'h4d21; // Arbitrary value
  localparam int WID[4] = '{1, 2, 4, 1};
  localparam logic [3:0] OE[4] = '{4'h2, 4'h3, 4'hf, 4'h2};
  localparam int SH[4] = '{SECTOR_SHIFT, BLOCK32_SHIFT, BLOCK64_SHIFT, 0};
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic select_n_in, sclk_in, tx_take_out, rx_valid_out, selected_out, frame_end_out;
  logic paused_out, quad_refused_out, status_write_block_out;
  logic [3:0] io_lane_in, io_lane_out, io_lane_oe_out, host_lane;
  logic quad_enable_bit_in = 1'b0;
  logic status_lock_bit_0_in = 1'b0;
  lane_mode_t lane_mode_in = LANE_SINGLE;
  logic drive_in = 1'b0;
  logic prog_start_in = 1'b0;
  logic prog_phase_in = 1'b0;
  logic [7:0] tx_byte_in = 8'h00;
  logic [7:0] rx_byte_out, id_byte_out;
  logic [ADDR_W-1:0] prog_addr_in = '0;
  logic [ADDR_W-1:0] erase_addr_in = '0;
  logic [ADDR_W-1:0] prog_addr_out, erase_base_out;
  logic [PROG_CNT_W-1:0] prog_count_out;
  erase_kind_t erase_kind_in = ERASE_SECTOR;
  logic [ID_IDX_W-1:0] id_index_in = '0;
  logic [31:0] seed = 32'ha8d1266b;
  logic [7:0] exp_q[$];
  bit watch = 1'b1;
  int errors = 0;
  int tests_run = 0;
  int takes = 0;
  int ends = 0;
  // ==========================================================
  // Clock, pins and instances
  always #2 core_clk_in = ~core_clk_in;
  assign io_lane_in = (io_lane_oe_out & io_lane_out) | (~io_lane_oe_out & host_lane);
  flash_pin_front #(.UNIQUE_ID(UID), .MFR_ID(MFR), .DEVICE_ID(DEV)) dut_u (
    .core_clk_in, .rst_b_in, .select_n_in, .sclk_in, .io_lane_in, .io_lane_out,
    .io_lane_oe_out, .quad_enable_bit_in, .status_lock_bit_0_in, .lane_mode_in, .drive_in,
    .tx_byte_in, .tx_take_out, .rx_byte_out, .rx_valid_out, .selected_out, .frame_end_out,
    .paused_out, .quad_refused_out, .status_write_block_out, .prog_start_in, .prog_phase_in,
    .prog_addr_in, .prog_addr_out, .prog_count_out, .erase_kind_in, .erase_addr_in,
    .erase_base_out, .id_index_in, .id_byte_out
  );
  flash_host_model host_u (
    .lane_in(io_lane_in), .select_n_out(select_n_in), .sclk_out(sclk_in), .lane_out(host_lane)
  );
  // ==========================================================
  // Helpers
  function logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Note the byte, then send it
  task automatic put(input logic [7:0] b, input int w);
    logic [7:0] r;
    exp_q.push_back(b);
    host_u.xfer(b, w, 8 / w, r);
  endtask : put
  // Write then read one byte in lane mode i
  task automatic mode_frame(input int i);
    logic [7:0] b;
    logic [7:0] r;
    int t0;
    int e0;
    b = 8'(next_rand());
    @(posedge core_clk_in);
    lane_mode_in <= (i == 3) ? LANE_QUAD : lane_mode_t'(2'(i));
    quad_enable_bit_in <= (i == 2);
    host_u.open_frame(i == 1);
    t0 = takes;
    e0 = ends;
    check(selected_out, 1'b1);
    check(quad_refused_out, i == 3);
    put(b, WID[i]);
    b = 8'(next_rand());
    watch = 1'b0;
    @(posedge core_clk_in);
    drive_in <= 1'b1;
    tx_byte_in <= b;
    host_u.xfer(8'h00, WID[i], 8 / WID[i], r);
    check(r, b);
    check(io_lane_oe_out, OE[i]);
    @(posedge core_clk_in);
    drive_in <= 1'b0;
    host_u.close_frame();
    check(io_lane_oe_out, 4'h0);
    check(20'(takes - t0), 20'h1);
    check(20'(ends - e0), 20'h1);
    watch = 1'b1;
  endtask : mode_frame
  // Each byte received while watch is set meets the oldest note
  always @(posedge core_clk_in)
    if (rx_valid_out === 1'b1 && watch)
    begin
      if (exp_q.size() == 0)
        check(20'h1, 20'h0);
      else
        check(rx_byte_out, exp_q.pop_front());
    end
  // Count take and frame end pulses
  always @(posedge core_clk_in)
  begin
    takes <= takes + int'(tx_take_out === 1'b1);
    ends <= ends + int'(frame_end_out === 1'b1);
  end
  // Hang guard
  initial
  begin
    #200000;
    check(20'h1, 20'h0);
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] r;
    logic [7:0] b;
    logic [19:0] a;
    #1;
    host_u.open_frame(1'b0);
    repeat (10) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    host_u.xfer(8'ha5, 1, 8, r);
    check(selected_out, 1'b0);
    host_u.close_frame();
    check(20'(ends), 20'h0);
    $display("test select after reset done");
    for (int i = 0; i < 4; i++)
      mode_frame(i);
    $display("test lane modes done");
    @(posedge core_clk_in);
    lane_mode_in <= LANE_SINGLE;
    quad_enable_bit_in <= 1'b0;
    b = 8'(next_rand());
    exp_q.push_back(b);
    host_u.open_frame(1'b0);
    host_u.xfer(b, 1, 4, r);
    host_u.set_pin(3, 1'b0);
    #40 check(paused_out, 1'b1);
    host_u.xfer(~b, 1, 4, r);
    host_u.set_pin(3, 1'b1);
    #40 check(paused_out, 1'b0);
    host_u.xfer(b << 4, 1, 4, r);
    host_u.close_frame();
    $display("test pause done");
    host_u.set_pin(2, 1'b0);
    for (int q = 0; q < 2; q++)
    begin
      @(posedge core_clk_in);
      status_lock_bit_0_in <= 1'b1;
      quad_enable_bit_in <= 1'(q);
      repeat (6) @(posedge core_clk_in);
      check(status_write_block_out, q == 0);
    end
    host_u.set_pin(2, 1'b1);
    $display("test write protect done");
    host_u.open_frame(1'b0);
    host_u.xfer(8'h5a, 1, 5, r);
    host_u.close_frame();
    @(posedge core_clk_in);
    lane_mode_in <= LANE_QUAD;
    prog_addr_in <= 20'h120fe;
    prog_start_in <= 1'b1;
    prog_phase_in <= 1'b1;
    @(posedge core_clk_in);
    prog_start_in <= 1'b0;
    host_u.open_frame(1'b0);
    for (int n = 1; n <= 257; n++)
    begin
      put(8'(next_rand()), 4);
      if (n == 3)
        check(prog_addr_out, 20'h12001);
    end
    check(prog_count_out, 9'h100);
    host_u.close_frame();
    @(posedge core_clk_in);
    prog_phase_in <= 1'b0;
    $display("test program page done");
    for (int k = 0; k < 4; k++)
    begin
      a = 20'(next_rand());
      @(posedge core_clk_in);
      erase_kind_in <= erase_kind_t'(2'(k));
      erase_addr_in <= a;
      repeat (2) @(posedge core_clk_in);
      #1 check(erase_base_out, k == 3 ? 20'h0 : a & ~((20'h1 << SH[k]) - 20'h1));
    end
    $display("test erase units done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge core_clk_in);
      id_index_in <= 4'(i);
      repeat (2) @(posedge core_clk_in);
      #1 check(id_byte_out, i < 8 ? UID[63 - 8 * i -: 8] : i == 8 ? MFR :
        i == 9 ? DEV[15:8] : i == 10 ? DEV[7:0] : 8'h00);
    end
    $display("test identity done");
    give_verdict();
  end
endmodule : flash_pin_front_tb_top
